/* File: design/aim_control.sv */
// Interrupt, DMA and signal routing control bank behind an APB slave.
module aim_control #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter and FIFO state.
  input wire logic fifo_not_empty,
  input wire logic fifo_full,
  input wire logic conversion_busy,
  input wire logic [15:0] dma_count,
  // Update, parallel port and timebase signals.
  input wire logic external_update_input,
  input wire logic update_counter_out,
  input wire logic port_a_ready_line,
  input wire logic port_b_ready_line,
  input wire logic timebase_select,
  input wire logic timebase_1mhz,
  input wire logic timebase_counter_out,
  // Counters feeding the routing.
  input wire logic sample_counter_out,
  input wire logic scan_counter_out,
  input wire logic scan_clock_connector,
  // External convert pin.
  input wire logic external_convert_pin_in,
  output logic external_convert_pin_out,
  output logic external_convert_pin_oe_n,
  // Scan interval connector line.
  input wire logic scan_interval_connector_line_in,
  output logic scan_interval_connector_line_out,
  output logic scan_interval_connector_line_oe_n,
  // Results.
  output logic irq,
  output logic dma_request,
  output logic convert_start,
  output logic converter_clear,
  output logic scan_counter_clock,
  output logic scan_run,
  output aim_pkg::aim_mux_s mux_select
);

  aim_pkg::aim_enable_s enable;
  aim_pkg::aim_routing_s routing;
  aim_pkg::aim_status_s status;
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic conv_clear_wr;
  logic tc_clear_wr;
  logic timer_clear_wr;
  logic update_pending;
  logic tc_pending;
  logic collision_pending;
  logic error_pending;
  logic tc_wrap;
  logic ext_conv_prev;
  logic sample_prev;
  logic [15:0] dma_count_prev;
  logic ext_conv_fall;
  logic next_convert;
  logic interval_clock;

  // Byte address of a register index.
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = ADDR_W'({idx, 2'b00});
  endfunction

  // True when the bus address selects the given register index.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == reg_addr(idx));
  endfunction

  // APB phase decode; the slave answers in the first access cycle.
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign pready = 1'b1;
  assign mapped = hit(paddr, aim_pkg::IDX_IRQ_DMA) | hit(paddr, aim_pkg::IDX_CONV_CLEAR)
                | hit(paddr, aim_pkg::IDX_TC_CLEAR) | hit(paddr, aim_pkg::IDX_ROUTING)
                | hit(paddr, aim_pkg::IDX_TIMER_CLEAR) | hit(paddr, aim_pkg::IDX_STATUS);
  assign pslverr = access & ~mapped;

  // Writes to the clear locations act as one-cycle strobes.
  assign conv_clear_wr = wr & hit(paddr, aim_pkg::IDX_CONV_CLEAR);
  assign tc_clear_wr = wr & hit(paddr, aim_pkg::IDX_TC_CLEAR);
  assign timer_clear_wr = wr & hit(paddr, aim_pkg::IDX_TIMER_CLEAR);

  // Interrupt and DMA enable register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= aim_pkg::IRQ_DMA_RST;
    end else if (wr && hit(paddr, aim_pkg::IDX_IRQ_DMA)) begin
      enable <= aim_pkg::aim_enable_s'(pwdata[7:0]);
    end
  end

  // Routing register; the top three bits are never stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routing <= aim_pkg::ROUTING_RST;
    end else if (wr && hit(paddr, aim_pkg::IDX_ROUTING)) begin
      routing <= aim_pkg::aim_routing_s'({3'h0, pwdata[4:0]});
    end
  end

  // Status word shows the pending sources; control registers read zero.
  always_comb begin
    status = '0;
    status.data_available = fifo_not_empty;
    status.error_pending = error_pending;
    status.collision_pending = collision_pending;
    status.terminal_count_pending = tc_pending;
    status.update_pending = update_pending;
  end

  // Read data is latched in the setup cycle so it comes from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= (!pwrite && hit(paddr, aim_pkg::IDX_STATUS)) ? {24'h0, status} : 32'h0;
    end
  end

  // Converter clear strobe passed on to the FIFO and conversion logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_clear <= 1'b0;
    end else begin
      converter_clear <= conv_clear_wr;
    end
  end

  // Edge history of the convert sources and the DMA count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_conv_prev <= 1'b1;
      sample_prev <= 1'b1;
      dma_count_prev <= aim_pkg::TC_WRAP_TO; // Not the wrap start, so reset makes no false wrap.
    end else begin
      ext_conv_prev <= external_convert_pin_in;
      sample_prev <= sample_counter_out;
      dma_count_prev <= dma_count;
    end
  end

  // A low pulse on the pin starts a conversion unless inhibited or driven.
  assign ext_conv_fall = ext_conv_prev & ~external_convert_pin_in;
  assign next_convert = (ext_conv_fall & ~routing.external_convert_inhibit
                        & ~routing.convert_line_drive)
                      | (sample_prev & ~sample_counter_out);

  // Convert start pulse to the converter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      convert_start <= 1'b0;
    end else begin
      convert_start <= next_convert;
    end
  end

  // Counter edge flag from the update input or the update counter.
  aim_event_flag #(.N(2)) u_update_flag (
    .pclk(pclk),
    .presetn(presetn),
    .level({external_update_input, update_counter_out}),
    .arm(enable.update_edge_irq_enable),
    .clear(timer_clear_wr),
    .pending(update_pending)
  );

  // Terminal count flag on the wrap of the DMA transfer count.
  assign tc_wrap = (dma_count_prev == aim_pkg::TC_WRAP_FROM)
                 & (dma_count == aim_pkg::TC_WRAP_TO);
  aim_event_flag #(.N(1)) u_tc_flag (
    .pclk(pclk),
    .presetn(presetn),
    .level(tc_wrap),
    .arm(enable.terminal_count_irq_enable),
    .clear(tc_clear_wr),
    .pending(tc_pending)
  );

  // Collision flag when a convert arrives during a conversion.
  aim_event_flag #(.N(1)) u_collision_flag (
    .pclk(pclk),
    .presetn(presetn),
    .level(next_convert & conversion_busy),
    .arm(1'b1),
    .clear(conv_clear_wr),
    .pending(collision_pending)
  );

  // Error condition is the FIFO-full flag or the collision flag.
  assign error_pending = fifo_full | collision_pending;

  // Enabled pending sources combine onto the single interrupt line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (enable.data_ready_irq_enable & fifo_not_empty)
           | (enable.conversion_error_irq_enable & error_pending)
           | update_pending
           | tc_pending
           | (enable.parallel_port_irq_enable
              & (port_a_ready_line | port_b_ready_line));
    end
  end

  // DMA request follows data availability while enabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_request <= 1'b0;
    end else begin
      dma_request <= enable.dma_request_enable & fifo_not_empty;
    end
  end

  // Convert pin direction and the conditioned sample counter copy.
  assign external_convert_pin_oe_n = ~routing.convert_line_drive;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_convert_pin_out <= 1'b1;
    end else begin
      external_convert_pin_out <= sample_counter_out;
    end
  end

  // Scan connector line carries the scan counter output unless received.
  assign scan_interval_connector_line_oe_n = routing.scan_interval_receive;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_interval_connector_line_out <= 1'b0;
    end else begin
      scan_interval_connector_line_out <= scan_counter_out;
    end
  end

  // Interval clock source picked by the receive bit.
  assign interval_clock = routing.scan_interval_receive
                        ? scan_interval_connector_line_in : scan_counter_out;

  // Scan gating and the scan counter clock source.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_run <= 1'b1;
      scan_counter_clock <= 1'b0;
    end else begin
      scan_run <= routing.interval_scan_select ? interval_clock : 1'b1;
      if (routing.interval_scan_select) begin
        scan_counter_clock <= timebase_select ? timebase_counter_out
                                              : timebase_1mhz;
      end else begin
        scan_counter_clock <= scan_clock_connector;
      end
    end
  end

  // Multiplexer selection from the channel field and input mode.
  function automatic aim_pkg::aim_mux_s mux_pick(input logic balanced_input_mode, input logic [2:0] ch);
    mux_pick.mux1_channel = balanced_input_mode ? {ch[2:1], 1'b0} : ch;
    mux_pick.mux2_channel = balanced_input_mode ? {ch[2:1], 1'b1} : 3'h0;
    mux_pick.mux2_common = ~balanced_input_mode;
  endfunction

  // Channel field is taken from the low bits of the last bus write to the status address.
  logic [2:0] channel_select;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select <= 3'h0;
      mux_select <= '0;
    end else begin
      if (wr && hit(paddr, aim_pkg::IDX_STATUS)) begin
        channel_select <= pwdata[2:0];
      end
      mux_select <= mux_pick(routing.input_mode_select, channel_select);
    end
  end

  // Checks run on the bus clock and are idle during reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence tc_wrap_armed;
    enable.terminal_count_irq_enable && tc_wrap;
  endsequence

  sequence update_edge_armed;
    enable.update_edge_irq_enable && !timer_clear_wr
    && ($rose(external_update_input) || $rose(update_counter_out));
  endsequence

  data_ready_irq_a: assert property (
    enable.data_ready_irq_enable && fifo_not_empty |=> irq)
    else $error("Data waiting did not raise the interrupt.");

  error_irq_a: assert property (
    enable.conversion_error_irq_enable && fifo_full |=> irq)
    else $error("FIFO full did not raise the interrupt.");

  error_clear_a: assert property (
    conv_clear_wr && !(next_convert && conversion_busy) |=> !collision_pending)
    else $error("Converter clear left a collision pending.");

  update_set_a: assert property (
    update_edge_armed |=> update_pending ##1 irq)
    else $error("Update edge did not raise the interrupt.");

  update_hold_a: assert property (
    update_pending && !timer_clear_wr |=> update_pending)
    else $error("Update interrupt dropped without its clear.");

  tc_set_a: assert property (
    tc_wrap_armed |=> tc_pending)
    else $error("Count wrap did not raise terminal count.");

  tc_hold_a: assert property (
    tc_pending && !tc_clear_wr |=> tc_pending)
    else $error("Terminal count dropped without its clear.");

  dma_gate_a: assert property (
    !enable.dma_request_enable ##1 !enable.dma_request_enable |-> !dma_request)
    else $error("DMA request issued while disabled.");

  convert_inhibit_a: assert property (
    ext_conv_fall && routing.external_convert_inhibit && sample_prev == sample_counter_out
    |=> !convert_start)
    else $error("Inhibited external convert started a conversion.");

  drive_pin_a: assert property (
    routing.convert_line_drive |-> !external_convert_pin_oe_n)
    else $error("Convert pin not driven with drive bit set.");

  pin_copy_a: assert property (
    routing.convert_line_drive |=> external_convert_pin_out == $past(sample_counter_out))
    else $error("Convert pin does not carry the sample counter copy.");

  continuous_scan_a: assert property (
    !routing.interval_scan_select |=> scan_run)
    else $error("Continuous scanning did not keep the scan running.");

endmodule

/* File: design/aim_pkg.sv */
// Package with register map, field layouts and reset values of the control bank.
// Summary of operation
// - Data waiting raises interrupt when its enable set.
// - FIFO-full or collision error raises enabled interrupt.
// - Converter-clear write removes pending collision error interrupt.
// - Enabled rising update edge raises interrupt.
// - Update interrupt pends until timer-clear write.
// - Enabled DMA count wrap zero to FFFF interrupts.
// - Only terminal-count clear write removes wrap interrupt.
// - Enabled parallel-port ready lines raise interrupt.
// - Enabled DMA request whenever FIFO holds data.
// - Routing register write-only at 0F, bits 7-5 ignored.
// - Uninhibited, undriven external convert low pulses convert.
// - Single-ended: mux one channel, mux two common.
// - Differential: both muxes select a channel pair.
// - Drive bit turns convert pin into counter output.
// - Receive bit picks connector line as interval clock.
// - Interval bit selects interval or continuous scanning.
// - Interval scanning clocks scan counter from sample timebase.
// - Reset clears all routing bits.
// - Convert during busy conversion sets collision error.
package aim_pkg;

  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] IDX_IRQ_DMA = 8'h02;
  localparam logic [7:0] IDX_CONV_CLEAR = 8'h08;
  localparam logic [7:0] IDX_TC_CLEAR = 8'h0a;
  localparam logic [7:0] IDX_ROUTING = 8'h0f;
  localparam logic [7:0] IDX_TIMER_CLEAR = 8'h14;
  localparam logic [7:0] IDX_STATUS = 8'h15;

  // Reset values of the two control registers.
  localparam logic [7:0] IRQ_DMA_RST = 8'h00;
  localparam logic [7:0] ROUTING_RST = 8'h00;

  // DMA transfer count values that mark the terminal-count wrap.
  localparam logic [15:0] TC_WRAP_FROM = 16'h0000;
  localparam logic [15:0] TC_WRAP_TO = 16'hffff;

  // Interrupt and DMA enable register, bit 7 down to bit 0.
  typedef struct packed {
    logic [1:0] ignored;
    logic data_ready_irq_enable;
    logic conversion_error_irq_enable;
    logic update_edge_irq_enable;
    logic terminal_count_irq_enable;
    logic parallel_port_irq_enable;
    logic dma_request_enable;
  } aim_enable_s;

  // Signal routing register, bit 7 down to bit 0.
  typedef struct packed {
    logic [2:0] ignored;
    logic external_convert_inhibit;
    logic input_mode_select;
    logic convert_line_drive;
    logic scan_interval_receive;
    logic interval_scan_select;
  } aim_routing_s;

  // Status word, bit 7 down to bit 0.
  typedef struct packed {
    logic [2:0] zero;
    logic update_pending;
    logic terminal_count_pending;
    logic collision_pending;
    logic error_pending;
    logic data_available;
  } aim_status_s;

  // Analog multiplexer selection.
  typedef struct packed {
    logic [2:0] mux1_channel;
    logic [2:0] mux2_channel;
    logic mux2_common;
  } aim_mux_s;

endpackage

/* File: design/aim_event_flag.sv */
// Sticky event flag that catches a rising edge on any of its inputs.
module aim_event_flag #(
  parameter int N = 1
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Event side.
  input wire logic [N-1:0] level,
  input wire logic arm,
  input wire logic clear,
  // Flag.
  output logic pending
);

  logic [N-1:0] prev;
  logic rise;

  // Remember the inputs to find rising edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= '0;
    end else begin
      prev <= level;
    end
  end

  assign rise = |(level & ~prev);

  // The flag holds until cleared; a new edge in the clear cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
    end else begin
      pending <= (arm & rise) | (pending & ~clear);
    end
  end

endmodule

/* File: sim/aim_connector_model.sv */
// Connector side model that resolves the two shared lines of the control bank.
module aim_connector_model (
  // Clock.
  input wire logic pclk,
  // External convert line.
  input wire logic conv_out,
  input wire logic conv_oe_n,
  input wire logic conv_far_en,
  input wire logic conv_far_level,
  output logic conv_in,
  // Scan interval line.
  input wire logic scan_out,
  input wire logic scan_oe_n,
  input wire logic scan_far_en,
  input wire logic scan_far_level,
  output logic scan_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_pat = 1'b0;
  // A released scan line shows a changing pattern, so no stale value can pass for data.
  always_ff @(posedge pclk) begin
    idle_pat <= ~idle_pat;
  end
  // The convert line is active low and is pulled up while nobody drives it.
  assign conv_in = !conv_oe_n ? conv_out : (conv_far_en ? conv_far_level : 1'b1);
  assign scan_in = !scan_oe_n ? scan_out : (scan_far_en ? scan_far_level : idle_pat);
endmodule

/* File: sim/acq_interrupt_dma_and_signal_mux_control_bench.sv */
// Self-checking bench for the interrupt, DMA and signal routing control bank.
module acq_interrupt_dma_and_signal_mux_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_EN = aim_pkg::IDX_IRQ_DMA << 2;
  localparam logic [7:0] A_CLR = aim_pkg::IDX_CONV_CLEAR << 2;
  localparam logic [7:0] A_TC = aim_pkg::IDX_TC_CLEAR << 2;
  localparam logic [7:0] A_RT = aim_pkg::IDX_ROUTING << 2;
  localparam logic [7:0] A_TMR = aim_pkg::IDX_TIMER_CLEAR << 2;
  localparam logic [7:0] A_ST = aim_pkg::IDX_STATUS << 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr;
  logic fifo_not_empty = 1'b0, fifo_full = 1'b0, conversion_busy = 1'b0;
  logic [15:0] dma_count = 16'h1234;
  logic upd_in = 1'b0, upd_cnt = 1'b0, port_a = 1'b0, port_b = 1'b0;
  logic tb_sel = 1'b0, tb_1m = 1'b0, tb_cnt = 1'b0;
  logic sample_counter_out = 1'b1, scan_counter_out = 1'b0, scan_conn = 1'b0;
  logic conv_in, conv_out, conv_oe_n, scan_in, scan_out, scan_oe_n;
  logic conv_far_en = 1'b0, conv_far_lvl = 1'b1, scan_far_en = 1'b0, scan_far_lvl = 1'b0;
  logic irq, dma_request, convert_start, converter_clear, scan_counter_clock, scan_run;
  aim_pkg::aim_mux_s mux_select;
  int n_mismatch = 0, n_checks = 0, n_conv = 0, n_clr = 0, cyc = 0;

  aim_control #(.ADDR_W(8)) aim_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fifo_not_empty(fifo_not_empty), .fifo_full(fifo_full),
    .conversion_busy(conversion_busy), .dma_count(dma_count),
    .external_update_input(upd_in), .update_counter_out(upd_cnt),
    .port_a_ready_line(port_a), .port_b_ready_line(port_b), .timebase_select(tb_sel),
    .timebase_1mhz(tb_1m), .timebase_counter_out(tb_cnt),
    .sample_counter_out(sample_counter_out), .scan_counter_out(scan_counter_out),
    .scan_clock_connector(scan_conn), .external_convert_pin_in(conv_in),
    .external_convert_pin_out(conv_out), .external_convert_pin_oe_n(conv_oe_n),
    .scan_interval_connector_line_in(scan_in), .scan_interval_connector_line_out(scan_out),
    .scan_interval_connector_line_oe_n(scan_oe_n), .irq(irq), .dma_request(dma_request),
    .convert_start(convert_start), .converter_clear(converter_clear),
    .scan_counter_clock(scan_counter_clock), .scan_run(scan_run), .mux_select(mux_select));

  aim_connector_model aim_connector_model_inst (
    .pclk(pclk), .conv_out(conv_out), .conv_oe_n(conv_oe_n), .conv_far_en(conv_far_en),
    .conv_far_level(conv_far_lvl), .conv_in(conv_in), .scan_out(scan_out),
    .scan_oe_n(scan_oe_n), .scan_far_en(scan_far_en), .scan_far_level(scan_far_lvl),
    .scan_in(scan_in));

  // Clock of 25 ns period.
  always #12.5 pclk = ~pclk;

  // Counts one-cycle pulses and clock cycles.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    n_conv <= n_conv + (convert_start === 1'b1);
    n_clr <= n_clr + (converter_clear === 1'b1);
  end

  // Cuts a hang short.
  always @(posedge pclk) begin
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; holds the request until pready is seen high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_reset();
    chk({conv_oe_n, scan_oe_n, scan_run, irq, dma_request}, 5'h14);
    xfer(1'b0, A_RT, 8'h00);
    chk(rdat, 32'h0);
    chk(rerr, 1'b0);
    xfer(1'b0, 8'h04, 8'h00);
    chk(rerr, 1'b1);
  endtask

  task automatic t_data_ready();
    fifo_not_empty <= 1'b1;
    xfer(1'b1, A_EN, 8'hc0);
    tick(4);
    chk({irq, dma_request}, 2'b00);
    xfer(1'b1, A_EN, 8'h21);
    tick(4);
    chk({irq, dma_request}, 2'b11);
    fifo_not_empty <= 1'b0;
    tick(4);
    chk({irq, dma_request}, 2'b00);
  endtask

  task automatic t_error();
    int c;
    c = n_clr;
    xfer(1'b1, A_EN, 8'h10);
    conversion_busy <= 1'b1;
    sample_counter_out <= 1'b0;
    tick(1);
    sample_counter_out <= 1'b1;
    tick(4);
    conversion_busy <= 1'b0;
    chk(irq, 1'b1);
    xfer(1'b0, A_ST, 8'h00);
    chk(rdat[2], 1'b1);
    xfer(1'b1, A_CLR, 8'h00);
    tick(3);
    chk(n_clr - c, 32'h1);
    chk(irq, 1'b0);
    fifo_full <= 1'b1;
    tick(4);
    chk(irq, 1'b1);
    xfer(1'b1, A_EN, 8'h00);
    tick(4);
    chk(irq, 1'b0);
    fifo_full <= 1'b0;
  endtask

  task automatic t_update();
    upd_in <= 1'b1;
    tick(4);
    upd_in <= 1'b0;
    xfer(1'b0, A_ST, 8'h00);
    chk(rdat[4], 1'b0);
    xfer(1'b1, A_EN, 8'h08);
    upd_in <= 1'b1;
    tick(4);
    chk(irq, 1'b1);
    upd_in <= 1'b0;
    xfer(1'b1, A_EN, 8'h00);
    tick(4);
    chk(irq, 1'b1);
    xfer(1'b1, A_TMR, 8'h00);
    tick(4);
    chk(irq, 1'b0);
    xfer(1'b1, A_EN, 8'h08);
    upd_cnt <= 1'b1;
    tick(4);
    chk(irq, 1'b1);
    upd_cnt <= 1'b0;
    xfer(1'b1, A_TMR, 8'h00);
    xfer(1'b1, A_EN, 8'h00);
  endtask

  task automatic t_term_count();
    dma_count <= 16'h0000;
    tick(2);
    dma_count <= 16'hffff;
    tick(4);
    xfer(1'b0, A_ST, 8'h00);
    chk(rdat[3], 1'b0);
    xfer(1'b1, A_EN, 8'h04);
    dma_count <= 16'h0000;
    tick(2);
    dma_count <= 16'hffff;
    tick(4);
    chk(irq, 1'b1);
    xfer(1'b1, A_CLR, 8'h00);
    xfer(1'b1, A_TMR, 8'h00);
    tick(4);
    chk(irq, 1'b1);
    xfer(1'b1, A_TC, 8'h00);
    tick(4);
    chk(irq, 1'b0);
  endtask

  task automatic t_port();
    xfer(1'b1, A_EN, 8'h02);
    port_a <= 1'b1;
    tick(4);
    chk(irq, 1'b1);
    port_a <= 1'b0;
    port_b <= 1'b1;
    tick(4);
    chk(irq, 1'b1);
    xfer(1'b1, A_EN, 8'h00);
    tick(4);
    chk(irq, 1'b0);
    port_b <= 1'b0;
  endtask

  // Pulses the convert line from the connector side and checks the number of starts.
  task automatic ext_pulse(input int exp);
    int c;
    c = n_conv;
    conv_far_en <= 1'b1;
    conv_far_lvl <= 1'b0;
    tick(1);
    conv_far_lvl <= 1'b1;
    tick(4);
    conv_far_en <= 1'b0;
    chk(n_conv - c, exp);
  endtask

  task automatic t_routing();
    xfer(1'b1, A_RT, 8'he0);
    tick(2);
    chk({conv_oe_n, scan_oe_n, scan_run}, 3'b101);
    ext_pulse(1);
    xfer(1'b1, A_RT, 8'h10);
    ext_pulse(0);
    xfer(1'b1, A_RT, 8'h04);
    sample_counter_out <= 1'b0;
    tick(3);
    chk({conv_oe_n, conv_in}, 2'b00);
    sample_counter_out <= 1'b1;
    tick(3);
    chk(conv_in, 1'b1);
    xfer(1'b1, A_ST, 8'h05);
    xfer(1'b1, A_RT, 8'h00);
    tick(2);
    chk(mux_select, 7'h51);
    xfer(1'b1, A_RT, 8'h08);
    tick(2);
    chk(mux_select, 7'h4a);
    scan_conn <= 1'b1;
    xfer(1'b1, A_RT, 8'h01);
    tb_1m <= 1'b1;
    tick(3);
    chk({scan_counter_clock, scan_run, scan_in}, 3'b100);
    tb_sel <= 1'b1;
    scan_far_en <= 1'b1;
    scan_far_lvl <= 1'b1;
    xfer(1'b1, A_RT, 8'h03);
    tick(3);
    chk({scan_counter_clock, scan_oe_n, scan_run}, 3'b011);
    xfer(1'b1, A_RT, 8'h00);
    scan_far_en <= 1'b0;
    tick(3);
    chk({scan_counter_clock, scan_run}, 2'b11);
  endtask

  // A reset in mid-run must clear every routing and enable bit again.
  task automatic t_midreset();
    xfer(1'b1, A_RT, 8'h1f);
    xfer(1'b1, A_EN, 8'h3f);
    fifo_not_empty <= 1'b1;
    tick(3);
    chk({conv_oe_n, scan_oe_n, irq, dma_request}, 4'h7);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(2);
    chk({conv_oe_n, scan_oe_n, scan_run, irq, dma_request}, 5'h14);
    fifo_not_empty <= 1'b0;
    ext_pulse(1);
  endtask

  // Main sequence: reset for five cycles, then every scenario in turn.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_data_ready();
    t_error();
    t_update();
    t_term_count();
    t_port();
    t_routing();
    t_midreset();
    tally_and_finish();
  end
endmodule
